// *** shared/lpg_pkg.sv ***
// Purpose: Shared constants for the LED pattern global control block
// Assumes: 50 MHz system clock, byte-wide registers behind a two-wire slave
// Notes: Phase times are held as counts of 10 ms ticks
package lpg_pkg;
   // Register offsets
   localparam logic [7:0] LPG_OFS_UPDATE = 8'h45;
   localparam logic [7:0] LPG_OFS_GCTL_TWO = 8'h61;
   localparam logic [7:0] LPG_OFS_GCTL_THREE = 8'h62;
   localparam logic [7:0] LPG_OFS_SOFT_RESET_ID = 8'h70;
   localparam logic [7:0] LPG_OFS_PAT_CONFIG = 8'h80;
   localparam logic [7:0] LPG_OFS_PAT_RUN = 8'h81;
   localparam logic [7:0] LPG_OFS_PAT_TIME_ZERO = 8'h82;
   localparam logic [7:0] LPG_OFS_PAT_TIME_ONE = 8'h83;
   localparam logic [7:0] LPG_OFS_PAT_LOOP = 8'h84;
   localparam logic [7:0] LPG_OFS_PAT_COUNT_LOW = 8'h85;
   localparam logic [7:0] LPG_OFS_LEVEL_HIGH = 8'h86;
   localparam logic [7:0] LPG_OFS_LEVEL_LOW = 8'h87;
   // Write keys and reset values
   localparam logic [7:0] LPG_SOFT_RESET_KEY = 8'h00;
   localparam logic [7:0] LPG_UPDATE_KEY = 8'h00;
   localparam logic [7:0] LPG_RESET_BYTE = 8'h00;
   // Field positions
   localparam int LPG_BCAST_DIS_BIT = 4;
   localparam int LPG_UPD_MODE_FAST_BIT = 3;
   localparam int LPG_UPD_MODE_SCALE_BIT = 2;
   localparam int LPG_SBW_BIT = 1;
   localparam int LPG_RGB_BIT = 0;
   localparam int LPG_SWITCH_BIT = 3;
   localparam int LPG_RAMP_BIT = 2;
   localparam int LPG_MODE_BIT = 1;
   localparam int LPG_ENABLE_BIT = 0;
   localparam int LPG_DONE_BIT = 2;
   localparam int LPG_RUNNING_BIT = 1;
   localparam int LPG_RUN_BIT = 0;
   localparam int LPG_STOP_MSB = 7;
   localparam int LPG_STOP_LSB = 6;
   localparam int LPG_START_MSB = 5;
   localparam int LPG_START_LSB = 4;
   // Timing
   localparam int LPG_CLK_PERIOD_NS = 20;
   localparam int LPG_TIME_UNIT_NS = 10_000_000;
   localparam int LPG_TICK_CYCLES = LPG_TIME_UNIT_NS / LPG_CLK_PERIOD_NS;
   // 0, .13, .26, .38, .51, .77, 1.04, 1.60, 2.10, 2.60, 3.10, 4.20, 5.20, 6.20, 7.30, 8.30 s
   localparam logic [9:0] LPG_PHASE_TICKS [16] = '{
      10'h000, 10'h00D, 10'h01A, 10'h026, 10'h033, 10'h04D, 10'h068, 10'h0A0,
      10'h0D2, 10'h104, 10'h136, 10'h1A4, 10'h208, 10'h26C, 10'h2DA, 10'h33E};
   typedef enum logic [2:0] {
      LPG_PH_IDLE = 3'b000,
      LPG_PH_A = 3'b001,
      LPG_PH_B = 3'b010,
      LPG_PH_FALL = 3'b011,
      LPG_PH_OFF = 3'b100
   } lpg_phase_t;
endpackage

// *** shared/lpg_tmr_if.sv ***
// Purpose: Link between the pattern sequencer and its phase timer
// Assumes: Both ends on the system clock
// Notes: start is a one-cycle pulse, expired a one-cycle pulse
`timescale 1ns/1ps
interface lpg_tmr_if;
   logic start;
   logic [3:0] code;
   logic expired;
   modport timer (input start, input code, output expired);
   modport user (output start, output code, input expired);
endinterface

// *** logic/lpg_phase_timer.sv ***
// Purpose: Times one breathing phase from a 4-bit duration code
// Assumes: Code is stable on the start pulse
// Notes: A new start abandons any phase still being timed
`timescale 1ns/1ps
module lpg_phase_timer
   import lpg_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = LPG_TICK_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   lpg_tmr_if.timer tmr
);
   logic busy_q;
   logic [31:0] tick_q;
   logic [9:0] unit_q;
   logic [9:0] target_q;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         tick_q <= '0;
         unit_q <= '0;
         target_q <= '0;
         tmr.expired <= 1'b0;
      end else begin
         tmr.expired <= 1'b0;
         if (tmr.start) begin
            busy_q <= 1'b1;
            tick_q <= '0;
            unit_q <= '0;
            target_q <= LPG_PHASE_TICKS[tmr.code];
         end else if (busy_q) begin
            if (unit_q == target_q) begin
               busy_q <= 1'b0;
               tmr.expired <= 1'b1;
            end else if (tick_q == 32'(TICK_CYCLES - 1)) begin
               tick_q <= '0;
               unit_q <= unit_q + 10'h001;
            end else begin
               tick_q <= tick_q + 32'h0000_0001;
            end
         end
      end
   end
endmodule

// *** logic/lpg_top.sv ***
// Purpose: Global update options, soft reset/ID and breathing pattern sequencer
// Assumes: Registers reached over a two-wire serial slave on the scl/sda pins
// Notes: Soft reset clears registers but leaves a transfer in progress alone
`timescale 1ns/1ps
// How it works
// R1 - Broadcast address answered unless disabled
// R2 - Update mode picks boundary or immediate apply
// R3 - Single-byte brightness write mode flag
// R4 - RGB mode shares brightness per three
// R5 - Writing 00h to reset clears registers
// R6 - Reset register reads chip identity code
// R7 - Manual switch bit turns LEDs on/off
// R8 - Mode selects manual or auto; ramp option
// R9 - Run rising edge starts the loop
// R10 - Running flag shows loop state
// R11 - Done flag set when pattern completes
// R12 - First time register holds two codes
// R13 - Fall time code with sixteen-step table
// R14 - Off time code, same table
// R15 - Stop point: off phase or second
// R16 - Start point selects restart phase
// R17 - Repeat count twelve bits, high nibble
// R18 - Zero repeat count loops forever
// R19 - Update register write applies pending values
// R20 - Level registers give fade max/min
// R21 - Reserved bits read zero
// R22 - Run edge gives one-cycle start pulse
module lpg_top
   import lpg_pkg::*;
#(
   parameter logic [6:0] I2C_ADDR = 7'h30,
   parameter logic [6:0] BCAST_ADDR = 7'h3C,
   parameter logic [7:0] CHIP_ID = 8'hA5, // Arbitrary value
   parameter int unsigned TICK_CYCLES = LPG_TICK_CYCLES
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   input wire logic pwm_period_end_in,
   output logic bright_update_out,
   output logic scale_update_out,
   output logic single_byte_write_mode_out,
   output logic rgb_shared_brightness_out,
   output logic [3:0] slew_ctl_out,
   output logic pattern_engine_enable_out,
   output logic pattern_running_state_out,
   output logic pattern_done_flag_out,
   output logic [2:0] pattern_phase_out,
   output logic pattern_led_on_out,
   output logic pattern_ramp_out,
   output logic [7:0] group_level_high_out,
   output logic [7:0] group_level_low_out
);
   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_ADDR = 3'b001,
      I_ACK = 3'b010,
      I_RX = 3'b011,
      I_TX = 3'b100,
      I_TXACK = 3'b101,
      I_LOAD = 3'b110
   } lpg_i2c_st_t;

   lpg_tmr_if tmr ();

   // Serial pin synchronisers
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      end else begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
      end
   end

   logic scl_rise_c, scl_fall_c, start_c, stop_c;
   assign scl_rise_c = scl_s2_q & ~scl_s3_q;
   assign scl_fall_c = ~scl_s2_q & scl_s3_q;
   assign start_c = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   assign stop_c = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

   lpg_i2c_st_t ist_q;
   logic [7:0] shift_q, ptr_q, wr_addr_q, wr_data_q, rd_byte_c, byte_c;
   logic [2:0] bit_q;
   logic have_ptr_q, is_read_q, ack_held_q, drive_q, wr_q, addr_hit_c, load_c;
   logic [4:0] gctl_two_q;
   logic [3:0] gctl_three_q, pat_cfg_q;
   logic run_q, run_prev_q, start_q, running_q, done_q, soft_rst_q, srst_c;
   logic [7:0] time_zero_q, time_one_q, loop_ctl_q, count_low_q, lvl_hi_q, lvl_lo_q;

   assign byte_c = {shift_q[6:0], sda_s2_q};
   always_comb begin
      addr_hit_c = (byte_c[7:1] == I2C_ADDR);
      if (byte_c[7:1] == BCAST_ADDR && !gctl_two_q[LPG_BCAST_DIS_BIT]) begin
         addr_hit_c = 1'b1; // [R1]
      end
   end
   assign load_c = (ist_q == I_LOAD) || (ist_q == I_ACK && ack_held_q && is_read_q);

   // Byte-level serial slave; pointer auto-increments per data byte
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ist_q <= I_IDLE;
         shift_q <= '0;
         ptr_q <= '0;
         bit_q <= '0;
         have_ptr_q <= 1'b0;
         is_read_q <= 1'b0;
         ack_held_q <= 1'b0;
         drive_q <= 1'b0;
         wr_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_q <= 1'b0;
         if (start_c) begin
            ist_q <= I_ADDR;
            bit_q <= '0;
            have_ptr_q <= 1'b0;
            drive_q <= 1'b0;
         end else if (stop_c) begin
            ist_q <= I_IDLE;
            drive_q <= 1'b0;
         end else if (scl_rise_c) begin
            case (ist_q)
               I_ADDR, I_RX: begin
                  shift_q <= byte_c;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     ack_held_q <= 1'b0;
                     ist_q <= I_ACK;
                     if (ist_q == I_ADDR) begin
                        is_read_q <= byte_c[0];
                        if (!addr_hit_c) begin
                           ist_q <= I_IDLE; // [R1]
                        end
                     end else if (!have_ptr_q) begin
                        ptr_q <= byte_c;
                        have_ptr_q <= 1'b1;
                     end else begin
                        wr_q <= 1'b1;
                        wr_addr_q <= ptr_q;
                        wr_data_q <= byte_c;
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               I_TX: begin
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     ist_q <= I_TXACK;
                  end
               end
               I_TXACK: begin
                  ist_q <= sda_s2_q ? I_IDLE : I_LOAD;
               end
               default: begin
               end
            endcase
         end else if (scl_fall_c) begin
            if (load_c) begin
               shift_q <= rd_byte_c;
               drive_q <= ~rd_byte_c[7];
               ptr_q <= ptr_q + 8'h01;
               bit_q <= '0;
               ack_held_q <= 1'b0;
               ist_q <= I_TX;
            end else begin
               case (ist_q)
                  I_ACK: begin
                     if (!ack_held_q) begin
                        drive_q <= 1'b1;
                        ack_held_q <= 1'b1;
                     end else begin
                        drive_q <= 1'b0;
                        bit_q <= '0;
                        ist_q <= I_RX;
                     end
                  end
                  I_TX: begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     drive_q <= ~shift_q[6];
                  end
                  I_TXACK: drive_q <= 1'b0;
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         sda_out <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end else begin
         sda_out <= 1'b0;
         sda_oe_n_out <= ~drive_q;
      end
   end

   // Read mux; unused bits read zero
   always_comb begin
      rd_byte_c = 8'h00;
      case (ptr_q)
         LPG_OFS_GCTL_TWO: rd_byte_c = {3'h0, gctl_two_q}; // [R21]
         LPG_OFS_GCTL_THREE: rd_byte_c = {4'h0, gctl_three_q};
         LPG_OFS_SOFT_RESET_ID: rd_byte_c = CHIP_ID; // [R6]
         LPG_OFS_PAT_CONFIG: rd_byte_c = {4'h0, pat_cfg_q};
         LPG_OFS_PAT_RUN: rd_byte_c = {5'h00, done_q, running_q, run_q};
         LPG_OFS_PAT_TIME_ZERO: rd_byte_c = time_zero_q;
         LPG_OFS_PAT_TIME_ONE: rd_byte_c = time_one_q;
         LPG_OFS_PAT_LOOP: rd_byte_c = loop_ctl_q;
         LPG_OFS_PAT_COUNT_LOW: rd_byte_c = count_low_q;
         LPG_OFS_LEVEL_HIGH: rd_byte_c = lvl_hi_q;
         LPG_OFS_LEVEL_LOW: rd_byte_c = lvl_lo_q;
         default: rd_byte_c = 8'h00;
      endcase
   end

   // Soft reset lands one cycle after the write
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_q && wr_addr_q == LPG_OFS_SOFT_RESET_ID
            && wr_data_q == LPG_SOFT_RESET_KEY; // [R5]
      end
   end
   assign srst_c = rst_in | soft_rst_q;

   always_ff @(posedge clk_sys_in) begin
      if (srst_c) begin // [R5]
         gctl_two_q <= LPG_RESET_BYTE[4:0];
         gctl_three_q <= LPG_RESET_BYTE[3:0];
         pat_cfg_q <= LPG_RESET_BYTE[3:0];
         run_q <= 1'b0;
         time_zero_q <= LPG_RESET_BYTE;
         time_one_q <= LPG_RESET_BYTE;
         loop_ctl_q <= LPG_RESET_BYTE;
         count_low_q <= LPG_RESET_BYTE;
         lvl_hi_q <= LPG_RESET_BYTE;
         lvl_lo_q <= LPG_RESET_BYTE;
      end else if (wr_q) begin
         case (wr_addr_q)
            LPG_OFS_GCTL_TWO: gctl_two_q <= wr_data_q[4:0]; // [R21]
            LPG_OFS_GCTL_THREE: gctl_three_q <= wr_data_q[3:0];
            LPG_OFS_PAT_CONFIG: pat_cfg_q <= wr_data_q[3:0]; // [R8]
            LPG_OFS_PAT_RUN: run_q <= wr_data_q[LPG_RUN_BIT];
            LPG_OFS_PAT_TIME_ZERO: time_zero_q <= wr_data_q; // [R12]
            LPG_OFS_PAT_TIME_ONE: time_one_q <= wr_data_q;
            LPG_OFS_PAT_LOOP: loop_ctl_q <= wr_data_q; // [R17]
            LPG_OFS_PAT_COUNT_LOW: count_low_q <= wr_data_q;
            LPG_OFS_LEVEL_HIGH: lvl_hi_q <= wr_data_q;
            LPG_OFS_LEVEL_LOW: lvl_lo_q <= wr_data_q;
            default: begin
            end
         endcase
      end
   end

   // Update strobes; boundary mode waits for the datapath carrier end
   logic upd_wr_c, upd_fast_c, pend_q, pend_scale_q;
   assign upd_wr_c = wr_q && wr_addr_q == LPG_OFS_UPDATE && wr_data_q == LPG_UPDATE_KEY;
   assign upd_fast_c = gctl_two_q[LPG_UPD_MODE_FAST_BIT];
   always_ff @(posedge clk_sys_in) begin
      if (srst_c) begin
         pend_q <= 1'b0;
         pend_scale_q <= 1'b0;
         bright_update_out <= 1'b0;
         scale_update_out <= 1'b0;
      end else begin
         bright_update_out <= (upd_wr_c && upd_fast_c)
            || (pend_q && pwm_period_end_in); // [R2] [R19]
         scale_update_out <= (upd_wr_c && upd_fast_c && gctl_two_q[LPG_UPD_MODE_SCALE_BIT])
            || (pend_q && pend_scale_q && pwm_period_end_in); // [R2]
         if (upd_wr_c && !upd_fast_c) begin
            pend_q <= 1'b1;
            pend_scale_q <= gctl_two_q[LPG_UPD_MODE_SCALE_BIT];
         end else if (pwm_period_end_in) begin
            pend_q <= 1'b0;
         end
      end
   end

   // Pattern sequencer
   lpg_phase_t ph_q, ph_d, restart_c;
   logic engine_on_c, enter_c, finish_c, inc_c, loop_end_c;
   logic [11:0] rpt_c, loop_cnt_q;
   assign rpt_c = {loop_ctl_q[3:0], count_low_q}; // [R17]
   assign engine_on_c = pat_cfg_q[LPG_ENABLE_BIT] & pat_cfg_q[LPG_MODE_BIT]; // [R8]

   always_comb begin
      case (loop_ctl_q[LPG_START_MSB:LPG_START_LSB]) // [R16]
         2'h0: restart_c = LPG_PH_A;
         2'h1: restart_c = LPG_PH_B;
         2'h2: restart_c = LPG_PH_FALL;
         default: restart_c = LPG_PH_OFF;
      endcase
   end

   always_comb begin
      ph_d = ph_q;
      enter_c = 1'b0;
      finish_c = 1'b0;
      inc_c = 1'b0;
      // Loop ends at start of off phase, else at start of second phase
      loop_end_c = (loop_ctl_q[LPG_STOP_MSB:LPG_STOP_LSB] == 2'h0) ?
         (ph_q == LPG_PH_FALL) : (ph_q == LPG_PH_A); // [R15]
      if (!engine_on_c) begin
         ph_d = LPG_PH_IDLE;
      end else if (start_q) begin
         ph_d = LPG_PH_A; // [R9]
         enter_c = 1'b1;
      end else if (ph_q != LPG_PH_IDLE && tmr.expired) begin
         enter_c = 1'b1;
         if (loop_end_c) begin
            if (rpt_c != 12'h000 && loop_cnt_q + 12'h001 >= rpt_c) begin
               finish_c = 1'b1;
               enter_c = 1'b0;
               ph_d = LPG_PH_IDLE;
            end else begin
               inc_c = (rpt_c != 12'h000); // [R18]
               ph_d = restart_c; // [R16]
            end
         end else begin
            case (ph_q)
               LPG_PH_A: ph_d = LPG_PH_B;
               LPG_PH_B: ph_d = LPG_PH_FALL;
               LPG_PH_FALL: ph_d = LPG_PH_OFF;
               default: ph_d = LPG_PH_A;
            endcase
         end
      end
   end

   // Phase code selection for the shared timer
   logic [3:0] code_c;
   always_comb begin
      case (ph_d)
         LPG_PH_A: code_c = time_zero_q[7:4]; // [R12]
         LPG_PH_B: code_c = time_zero_q[3:0]; // [R12]
         LPG_PH_FALL: code_c = time_one_q[7:4]; // [R13]
         default: code_c = time_one_q[3:0]; // [R14]
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_c) begin
         run_prev_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         run_prev_q <= run_q;
         start_q <= run_q & ~run_prev_q; // [R22] [R9]
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_c) begin
         ph_q <= LPG_PH_IDLE;
         loop_cnt_q <= '0;
         running_q <= 1'b0;
         tmr.start <= 1'b0;
         tmr.code <= '0;
      end else begin
         ph_q <= ph_d;
         running_q <= (ph_d != LPG_PH_IDLE); // [R10]
         tmr.start <= enter_c;
         tmr.code <= code_c;
         if (start_q) begin
            loop_cnt_q <= '0;
         end else if (inc_c) begin
            loop_cnt_q <= loop_cnt_q + 12'h001;
         end
      end
   end

   // Done is sticky; completion wins over a clearing write
   always_ff @(posedge clk_sys_in) begin
      if (srst_c) begin
         done_q <= 1'b0;
      end else if (finish_c) begin
         done_q <= 1'b1; // [R11]
      end else if (start_q || (wr_q && wr_addr_q == LPG_OFS_PAT_RUN
            && !wr_data_q[LPG_DONE_BIT])) begin
         done_q <= 1'b0;
      end
   end

   lpg_phase_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk_sys_in(clk_sys_in),
      .rst_in(srst_c),
      .tmr(tmr)
   );

   always_ff @(posedge clk_sys_in) begin
      if (srst_c) begin
         single_byte_write_mode_out <= 1'b0;
         rgb_shared_brightness_out <= 1'b0;
         slew_ctl_out <= '0;
         pattern_engine_enable_out <= 1'b0;
         pattern_running_state_out <= 1'b0;
         pattern_done_flag_out <= 1'b0;
         pattern_phase_out <= '0;
         pattern_led_on_out <= 1'b0;
         pattern_ramp_out <= 1'b0;
         group_level_high_out <= '0;
         group_level_low_out <= '0;
      end else begin
         single_byte_write_mode_out <= gctl_two_q[LPG_SBW_BIT]; // [R3]
         rgb_shared_brightness_out <= gctl_two_q[LPG_RGB_BIT]; // [R4]
         slew_ctl_out <= gctl_three_q;
         pattern_engine_enable_out <= pat_cfg_q[LPG_ENABLE_BIT];
         pattern_running_state_out <= running_q;
         pattern_done_flag_out <= done_q;
         pattern_phase_out <= ph_q;
         // Manual mode follows the switch; auto lights while looping
         pattern_led_on_out <= pat_cfg_q[LPG_MODE_BIT] ? running_q
            : pat_cfg_q[LPG_SWITCH_BIT]; // [R7]
         pattern_ramp_out <= pat_cfg_q[LPG_RAMP_BIT] & ~pat_cfg_q[LPG_MODE_BIT]; // [R8]
         group_level_high_out <= lvl_hi_q; // [R20]
         group_level_low_out <= lvl_lo_q; // [R20]
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   sequence s_soft_write;
      wr_q && wr_addr_q == LPG_OFS_SOFT_RESET_ID && wr_data_q == LPG_SOFT_RESET_KEY;
   endsequence
   sequence s_regs_cleared;
      soft_rst_q ##1 (gctl_two_q == 5'h00 && pat_cfg_q == 4'h0 && !run_q);
   endsequence
   a_soft_reset_clear: assert property (s_soft_write |=> s_regs_cleared) // [R5]
      else $error("soft reset did not clear registers");
   a_id_read_value: assert property (ptr_q == LPG_OFS_SOFT_RESET_ID |-> rd_byte_c == CHIP_ID) // [R6]
      else $error("identity code not returned");
   a_bcast_ignored: assert property (scl_rise_c && !start_c && !stop_c && ist_q == I_ADDR // [R1]
      && bit_q == 3'h7 && byte_c[7:1] == BCAST_ADDR && byte_c[7:1] != I2C_ADDR
      && gctl_two_q[LPG_BCAST_DIS_BIT] |=> ist_q == I_IDLE)
      else $error("disabled broadcast address answered");
   a_fast_update: assert property (upd_wr_c && upd_fast_c && !soft_rst_q |=> bright_update_out // [R2]
      && scale_update_out == $past(gctl_two_q[LPG_UPD_MODE_SCALE_BIT]))
      else $error("immediate update strobe wrong");
   a_boundary_wait: assert property (upd_wr_c && !upd_fast_c && !pend_q && !soft_rst_q // [R19]
      |=> !bright_update_out ##0 pend_q)
      else $error("boundary update fired early");
   a_start_pulse: assert property ($rose(run_q) && !soft_rst_q |=> start_q ##1 !start_q) // [R22]
      else $error("run edge did not give one start pulse");
   a_start_runs: assert property (start_q && engine_on_c && !soft_rst_q // [R10]
      |=> running_q && ph_q == LPG_PH_A ##1 tmr.start == 1'b0)
      else $error("start did not enter first phase");
   a_finish_flag: assert property (finish_c && !soft_rst_q |=> done_q && !running_q) // [R11]
      else $error("completion flag not set");
   a_forever_loop: assert property (ph_q != LPG_PH_IDLE && tmr.expired && loop_end_c // [R18]
      && rpt_c == 12'h000 && engine_on_c && !start_q && !soft_rst_q |=> running_q)
      else $error("zero count loop stopped");
   a_stop_at_fall: assert property (ph_q == LPG_PH_FALL && tmr.expired && engine_on_c // [R15]
      && loop_ctl_q[LPG_STOP_MSB:LPG_STOP_LSB] == 2'h0 && loop_ctl_q[LPG_START_MSB:LPG_START_LSB]
      != 2'h3 && !start_q && !soft_rst_q |=> ph_q != LPG_PH_OFF)
      else $error("loop ran past stop point");
endmodule

// *** bench/lpg_host.sv ***
// Purpose: Two-wire host model writing and reading device registers
// Assumes: Open-drain data line with pull-up, 8 clocks per half bit
// Notes: Released data reads high through the pull-up
`timescale 1ns/1ps
module lpg_host (
   input wire logic clk_sys_in,
   input wire logic sda_line_in,
   output logic scl_out,
   output logic sda_out,
   output logic rd_stb_out,
   output logic [7:0] rd_data_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
      rd_stb_out = 1'b0;
      rd_data_out = 8'h00;
   end
   task automatic half();
      repeat (8) @(posedge clk_sys_in);
      #2;
   endtask
   task automatic clk_bit(input logic b, output logic s);
      sda_out = b;
      half();
      scl_out = 1'b1;
      half();
      s = sda_line_in;
      scl_out = 1'b0;
   endtask
   // Also serves as repeated start
   task automatic start();
      sda_out = 1'b1;
      half();
      scl_out = 1'b1;
      half();
      sda_out = 1'b0;
      half();
      scl_out = 1'b0;
   endtask
   task automatic stop();
      sda_out = 1'b0;
      half();
      scl_out = 1'b1;
      half();
      sda_out = 1'b1;
      half();
   endtask
   // Ninth bit released: slave ack on writes, host nack on the read
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      logic s;
      for (int i = 0; i < 8; i++) begin
         clk_bit(d[7-i], s);
         q = {q[6:0], s};
      end
      clk_bit(1'b1, s);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, q);
      xfer(p, q);
      xfer(d, q);
      stop();
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] p);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, q);
      xfer(p, q);
      start();
      xfer({a, 1'b1}, q);
      xfer(8'hff, q);
      stop();
      rd_data_out = q;
      rd_stb_out = 1'b1;
      @(posedge clk_sys_in);
      #2 rd_stb_out = 1'b0;
   endtask
endmodule

// *** bench/tb_lpg_top.sv ***
// Purpose: Self-checking bench for the global control and pattern block
// Assumes: Phase tick shortened to 4 clocks
// Notes: Read results are checked against a queue of expected bytes
`timescale 1ns/1ps
module tb_lpg_top;
   import lpg_pkg::*;
   localparam logic [7:0] ID = 8'h5a; // Arbitrary value
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic pwm_end = 1'b0;
   logic scl, sda_h, sda_d, oe_n, sda_line, rd_stb, upd, sbw, rgb, done, supd, run_st, en, led, ramp;
   logic [7:0] rd_data, r, lvl_hi, lvl_lo;
   logic [3:0] slew;
   logic [7:0] exp_q[$];
   int err_count = 0;
   int samples_checked = 0;
   int upd_cnt = 0;
   int supd_cnt = 0;
   int seed = 32'hd76b;
   always #10 clk_sys_in = ~clk_sys_in;
   assign sda_line = sda_h & (oe_n | sda_d);
   lpg_host host_u (.clk_sys_in(clk_sys_in), .sda_line_in(sda_line), .scl_out(scl),
      .sda_out(sda_h), .rd_stb_out(rd_stb), .rd_data_out(rd_data));
   lpg_top #(.CHIP_ID(ID), .TICK_CYCLES(4)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_d), .sda_oe_n_out(oe_n),
      .pwm_period_end_in(pwm_end), .bright_update_out(upd), .scale_update_out(supd),
      .single_byte_write_mode_out(sbw), .rgb_shared_brightness_out(rgb), .slew_ctl_out(slew),
      .pattern_engine_enable_out(en), .pattern_running_state_out(run_st),
      .pattern_done_flag_out(done), .pattern_phase_out(), .pattern_led_on_out(led),
      .pattern_ramp_out(ramp), .group_level_high_out(lvl_hi), .group_level_low_out(lvl_lo));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.rd(7'h30, p);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      host_u.wr(7'h30, p, d);
   endtask
   task automatic close_out();
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      if (rd_stb === 1'b1 && exp_q.size() > 0) check(rd_data, exp_q.pop_front());
      if (upd === 1'b1) upd_cnt++;
      if (supd === 1'b1) supd_cnt++;
   end
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      err_count++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge clk_sys_in);
      #2 rst_in = 1'b0;
      repeat (4) @(posedge clk_sys_in);
      #2;
      rd(LPG_OFS_GCTL_TWO, 8'h00);
      rd(LPG_OFS_SOFT_RESET_ID, ID);
      r = 8'($random(seed));
      wr(LPG_OFS_GCTL_TWO, r & 8'hef);
      rd(LPG_OFS_GCTL_TWO, r & 8'h0f);
      check({6'h00, sbw, rgb}, {6'h00, r[1:0]});
      host_u.wr(7'h3c, LPG_OFS_GCTL_THREE, 8'h05);
      rd(LPG_OFS_GCTL_THREE, 8'h05);
      check({4'h0, slew}, 8'h05);
      wr(LPG_OFS_GCTL_TWO, 8'h18);
      host_u.wr(7'h3c, LPG_OFS_GCTL_THREE, 8'h0a);
      rd(LPG_OFS_GCTL_THREE, 8'h05);
      wr(LPG_OFS_UPDATE, 8'h00);
      check(upd_cnt[7:0], 8'h01);
      check(supd_cnt[7:0], 8'h00);
      wr(LPG_OFS_GCTL_TWO, 8'h04);
      wr(LPG_OFS_UPDATE, 8'h00);
      check(upd_cnt[7:0], 8'h01);
      @(posedge clk_sys_in);
      #2 pwm_end = 1'b1;
      @(posedge clk_sys_in);
      #2 pwm_end = 1'b0;
      repeat (4) @(posedge clk_sys_in);
      #2;
      check(upd_cnt[7:0], 8'h02);
      check(supd_cnt[7:0], 8'h01);
      wr(LPG_OFS_SOFT_RESET_ID, 8'h00);
      rd(LPG_OFS_GCTL_THREE, 8'h00);
      wr(LPG_OFS_PAT_TIME_ZERO, 8'h11);
      wr(LPG_OFS_PAT_TIME_ONE, 8'h11);
      wr(LPG_OFS_PAT_COUNT_LOW, 8'h01);
      wr(LPG_OFS_PAT_CONFIG, 8'h03);
      wr(LPG_OFS_PAT_RUN, 8'h01);
      check({7'h00, run_st}, 8'h01);
      for (int i = 0; i < 3000 && done !== 1'b1; i++) @(posedge clk_sys_in);
      #2;
      rd(LPG_OFS_PAT_RUN, 8'h05);
      wr(LPG_OFS_PAT_COUNT_LOW, 8'h00);
      wr(LPG_OFS_PAT_LOOP, 8'h10);
      wr(LPG_OFS_PAT_RUN, 8'h00);
      wr(LPG_OFS_PAT_RUN, 8'h01);
      repeat (600) @(posedge clk_sys_in);
      #2;
      check({7'h00, run_st}, 8'h01);
      wr(LPG_OFS_PAT_CONFIG, 8'h0c);
      check({5'h00, en, led, ramp}, 8'h03);
      r = 8'($random(seed));
      wr(LPG_OFS_LEVEL_HIGH, r);
      wr(LPG_OFS_LEVEL_LOW, ~r);
      check(lvl_hi, r);
      check(lvl_lo, ~r);
      close_out();
   end
endmodule
